// ### hdl/temp_alert_regs.vh
// constants for the temperature limit and rise-rate alert block
`ifndef TEMP_ALERT_REGS_VH
`define TEMP_ALERT_REGS_VH
`define TEMP_WIDTH 14
`define MODE_CONTINUOUS 2'h0
`define MODE_ONE_SHOT 2'h1
`define MODE_SHUTDOWN 2'h2
`define ALERT_MODE_INTERRUPT 1'h0
`define ALERT_MODE_COMPARATOR 1'h1
`define FLAG_HIGH 0
`define FLAG_LOW 1
`define FLAG_RISE 2
`define FLAG_COUNT 3
`define FLAGS_RESET 3'h0
`define CONV_TIME_US 6000
`define CLK_MHZ 100
`define CONV_CYCLES (`CONV_TIME_US * `CLK_MHZ)
`define STARTUP_TIME_US 500
`define STARTUP_CYCLES (`STARTUP_TIME_US * `CLK_MHZ)
`endif

// ### hdl/edge_sync.v
// two-flop synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module edge_sync (
    input wire core_clk,
    input wire reset,
    input wire async_in,
    output wire level,
    output wire rise,
    output wire fall
);
    reg stage1;
    reg stage2;
    reg stage3;
    always @(posedge core_clk) begin
        if (reset) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end
    assign level = stage2;
    assign rise = stage2 & ~stage3;
    assign fall = ~stage2 & stage3;
endmodule // edge_sync

// ### hdl/temp_limit_slew_alert.v
// temperature limit and rise-rate alert logic with conversion sequencing
// Function
// - a configuration bit enables or disables the limit warning.
// - when enabled, compare each completed result with lower and upper thresholds.
// - out-of-limit result sets its flag, which asserts alert if its flag_enable bit is set; latched or following depends on alert mode.
// - rise-rate threshold is a programmable unsigned magnitude.
// - each continuous conversion after the first compares increase over previous result; decreases never trigger.
// - increase above threshold sets the rise-rate warning flag.
// - rise rate is evaluated only in continuous conversion mode.
// - modes are continuous, one-shot and shutdown, chosen by configuration.
// - comparator mode asserts alert while any enabled flag is set.
// - in interrupt mode, reading the flags clears them and deasserts alert.
`timescale 1ns/1ps
`include "temp_alert_regs.vh"
module temp_limit_slew_alert #(
    parameter TW = `TEMP_WIDTH,
    parameter CONV_CYCLES = `CONV_CYCLES,
    parameter STARTUP_CYCLES = `STARTUP_CYCLES
) (
    input wire core_clk,
    input wire reset,
    input wire [1:0] conv_mode,
    input wire one_shot_start,
    input wire limit_enable,
    input wire alert_mode,
    input wire [`FLAG_COUNT-1:0] flag_enable,
    input wire signed [TW-1:0] lower_threshold,
    input wire signed [TW-1:0] upper_threshold,
    input wire [TW-1:0] rise_threshold,
    input wire signed [TW-1:0] sensor_sample,
    input wire flags_read_n,
    output reg signed [TW-1:0] temp_result,
    output reg [`FLAG_COUNT-1:0] event_flags,
    output reg [`FLAG_COUNT-1:0] status_level,
    output reg conversion_done,
    output reg converting,
    output reg link_ready,
    output wire alert_n
);
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_DONE = 2'h2;
    localparam CW = 32;

    reg [1:0] state;
    reg [1:0] next_state;
    // wide counters cover the real startup and conversion times at the core clock
    reg [CW-1:0] conv_count;
    reg [CW-1:0] start_count;
    reg conv_is_continuous;
    reg have_previous;
    reg signed [TW-1:0] previous_result;
    reg alert_mode_prev;

    wire read_pulse;
    wire flag_clear;
    wire [`FLAG_COUNT-1:0] next_flags;

    // the flags-read strobe comes from the link clock domain
    edge_sync read_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(~flags_read_n),
        .level(),
        .rise(read_pulse),
        .fall()
    );

    function out_high;
        input signed [TW-1:0] value;
        input signed [TW-1:0] limit;
        begin
            out_high = value > limit;
        end
    endfunction

    // finish marks the last conversion cycle; result and flags land on this edge
    wire finish = (state == ST_CONV) && (conv_count == CONV_CYCLES - 1);
    // one guard bit keeps the difference of two signed results from wrapping
    wire signed [TW:0] delta = {sensor_sample[TW-1], sensor_sample}
                             - {previous_result[TW-1], previous_result};
    // sign bit clear means increase; magnitude compared unsigned
    wire rise_hit = have_previous && conv_is_continuous && (conv_mode == `MODE_CONTINUOUS)
                  && !delta[TW] && (delta[TW-1:0] > rise_threshold);
    // no hysteresis: every result is judged against the limits on its own
    wire high_hit = limit_enable && out_high(sensor_sample, upper_threshold);
    wire low_hit = limit_enable && out_high(lower_threshold, sensor_sample);
    wire [`FLAG_COUNT-1:0] hits = {rise_hit, low_hit, high_hit};
    // switching from comparator to interrupt clears the flags
    wire to_interrupt = (alert_mode == `ALERT_MODE_INTERRUPT)
                      && (alert_mode_prev == `ALERT_MODE_COMPARATOR);

    // sequencing: startup hold-off, then continuous runs or one-shot requests
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_count == 0 && (conv_mode == `MODE_CONTINUOUS || one_shot_start))
                    next_state = ST_CONV;
            end
            ST_CONV: begin
                // shutdown drops a running continuous conversion; a one-shot runs to its end
                if (conv_mode == `MODE_SHUTDOWN && conv_is_continuous)
                    next_state = ST_IDLE;
                else if (finish)
                    next_state = ST_DONE;
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (reset) begin
            state <= ST_IDLE;
            conv_count <= 32'h0;
            start_count <= STARTUP_CYCLES;
            conv_is_continuous <= 1'b0;
            alert_mode_prev <= `ALERT_MODE_INTERRUPT;
            link_ready <= 1'b0;
            converting <= 1'b0;
        end else begin
            state <= next_state;
            alert_mode_prev <= alert_mode;
            // host must hold off the link until this counts out
            if (start_count != 0)
                start_count <= start_count - 32'h1;
            link_ready <= (start_count == 0);
            converting <= (next_state == ST_CONV);
            // holding one_shot_start in a non-continuous mode keeps restarting the count
            if (state != ST_CONV || (one_shot_start && conv_mode != `MODE_CONTINUOUS))
                conv_count <= 32'h0; // a new one-shot request restarts the conversion
            else
                conv_count <= conv_count + 32'h1;
            // the mode is frozen at the start so a later switch cannot fake a fixed interval
            if (state == ST_IDLE && next_state == ST_CONV)
                conv_is_continuous <= (conv_mode == `MODE_CONTINUOUS);
        end
    end

    // result capture; an aborted conversion never reaches finish, so no partial result lands
    always @(posedge core_clk) begin
        if (reset) begin
            temp_result <= {TW{1'b0}};
            status_level <= `FLAGS_RESET;
            conversion_done <= 1'b0;
        end else begin
            conversion_done <= finish;
            if (finish) begin
                temp_result <= sensor_sample;
                status_level <= hits;
            end
        end
    end

    // the previous sample is trusted only across back-to-back continuous conversions
    always @(posedge core_clk) begin
        if (reset) begin
            previous_result <= {TW{1'b0}};
            have_previous <= 1'b0;
        end else if (finish) begin
            if (conv_is_continuous) begin
                previous_result <= sensor_sample;
                have_previous <= 1'b1;
            end else begin
                have_previous <= 1'b0;
            end
        end else if (conv_mode != `MODE_CONTINUOUS) begin
            // leaving continuous mode breaks the fixed interval
            have_previous <= 1'b0;
        end
    end

    // next value of one flag bit; a hit always wins over a clear in the same cycle
    function flag_update;
        input held;
        input hit;
        input done;
        input clear;
        input comparator;
        begin
            if (done && comparator)
                flag_update = hit; // follows each result
            else if (done)
                flag_update = hit | (held & ~clear); // latched
            else if (clear)
                flag_update = 1'b0;
            else
                flag_update = held;
        end
    endfunction

    // a read only clears in interrupt mode; comparator flags just follow the results
    assign flag_clear = to_interrupt
                      || (read_pulse && alert_mode == `ALERT_MODE_INTERRUPT);

    genvar fi;
    generate
        for (fi = 0; fi < `FLAG_COUNT; fi = fi + 1) begin : flag_bit
            assign next_flags[fi] = flag_update(event_flags[fi], hits[fi], finish, flag_clear,
                                                alert_mode == `ALERT_MODE_COMPARATOR);
        end
    endgenerate

    always @(posedge core_clk) begin
        if (reset)
            event_flags <= `FLAGS_RESET;
        else
            event_flags <= next_flags;
    end

    // alert is active low; any enabled flag drives it
    assign alert_n = ~|(event_flags & flag_enable);
endmodule // temp_limit_slew_alert

// ### bench/temp_alert_chk.sv
// checker for the limit and rise-rate alert block
`timescale 1ns/1ps
module temp_alert_chk (
    input wire core_clk,
    input wire reset,
    input wire [1:0] conv_mode,
    input wire limit_enable,
    input wire alert_mode,
    input wire [2:0] flag_enable,
    input wire signed [13:0] lower_threshold,
    input wire signed [13:0] upper_threshold,
    input wire flags_read_n,
    input wire signed [13:0] temp_result,
    input wire [2:0] event_flags,
    input wire conversion_done,
    input wire alert_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    AST_ALERT_MAP: assert property (alert_n == !(|(event_flags & flag_enable)))
        else $error("alert pin disagrees with enabled flags");
    AST_HIGH_SET: assert property (conversion_done && limit_enable
        && temp_result > upper_threshold |-> event_flags[0]) else $error("high flag missing");
    AST_LOW_SET: assert property (conversion_done && limit_enable
        && temp_result < lower_threshold |-> event_flags[1]) else $error("low flag missing");
    AST_NO_LIMIT: assert property ($rose(event_flags[0]) |-> $past(limit_enable))
        else $error("high flag set while limits disabled");
    AST_RISE_MODE: assert property ($rose(event_flags[2]) |-> $past(conv_mode) == 2'h0)
        else $error("rise flag outside continuous mode");
    AST_FLAG_CAUSE: assert property ($rose(|event_flags) |-> conversion_done)
        else $error("flag set without a finished conversion");
    AST_READ_CLEAR: assert property (!alert_mode && $fell(flags_read_n)
        |-> ##[2:5] (event_flags == 3'h0 || conversion_done))
        else $error("read did not clear flags");
    AST_DONE_PULSE: assert property (conversion_done |=> !conversion_done)
        else $error("done is not a single pulse");
endmodule // temp_alert_chk
bind temp_limit_slew_alert temp_alert_chk temp_alert_chk_i (.*);

// ### bench/host_link.sv
// host model that reads the event flags over the link
`timescale 1ns/1ps
module host_link (
    output logic flags_read_n
);
    initial flags_read_n = 1'b1;
    // one 125 ns link period low marks a flags read
    task automatic read_flags();
        // start off the core clock edges so the strobe never races the sampler
        #103;
        flags_read_n = 1'b0;
        #125;
        flags_read_n = 1'b1;
    endtask
endmodule // host_link

// ### bench/tb.sv
// self-checking bench for the limit and rise-rate alert block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module tb;
    logic core_clk = 0, reset = 1, one_shot_start = 0, limit_enable = 1, alert_mode = 0;
    logic [1:0] conv_mode = 2'h0;
    logic [2:0] flag_enable = 3'h7, event_flags, status_level;
    logic signed [13:0] lower_threshold = -14'sh0064, upper_threshold = 14'sh0064;
    logic [13:0] rise_threshold = 14'h0014;
    logic signed [13:0] sensor_sample = 14'sh0000, temp_result;
    logic flags_read_n, conversion_done, converting, link_ready, alert_n;
    int err_count = 0, n_compared = 0;
    always #5 core_clk = ~core_clk;
    // short counts keep the run small
    temp_limit_slew_alert #(.CONV_CYCLES(200), .STARTUP_CYCLES(10)) temp_limit_slew_alert_i (
        .*);
    host_link host_link_i (.flags_read_n(flags_read_n));
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic step(input logic signed [13:0] s, input logic [2:0] exp,
                        input logic [2:0] h);
        int i;
        @(negedge core_clk);
        sensor_sample = s;
        one_shot_start = (conv_mode != 2'h0);
        @(negedge core_clk);
        one_shot_start = 1'b0;
        for (i = 0; i < 400 && conversion_done !== 1'b1; i++) @(negedge core_clk);
        if (i == 400) begin err_count++; complete_run(); end
        `CHK("event_flags", exp, event_flags)
        `CHK("alert_n", ~|(exp & flag_enable), alert_n)
        `CHK("temp_result", s, temp_result)
        `CHK("status_level", h, status_level)
    endtask
    task automatic rd();
        host_link_i.read_flags();
        repeat (4) @(negedge core_clk);
        `CHK("flags after read", 3'h0, event_flags)
    endtask
    initial begin
        int i;
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        for (i = 0; i < 100 && link_ready !== 1'b1; i++) @(negedge core_clk);
        if (i == 100) begin err_count++; complete_run(); end
        step(14'sh0032, 3'h0, 3'h0);
        step(14'sh00c8, 3'h5, 3'h5);
        step(14'sh00d2, 3'h5, 3'h1);
        rd();
        flag_enable = 3'h5;
        step(-14'sh00c8, 3'h2, 3'h2);
        step(-14'sh00b4, 3'h2, 3'h2);
        flag_enable = 3'h7;
        rd();
        limit_enable = 1'b0;
        step(14'sh01f4, 3'h4, 3'h4);
        rd();
        limit_enable = 1'b1;
        alert_mode = 1'b1;
        step(14'sh0000, 3'h0, 3'h0);
        step(14'sh012c, 3'h5, 3'h5);
        step(14'sh012c, 3'h1, 3'h1);
        step(14'sh0000, 3'h0, 3'h0);
        // shut down in the middle of a continuous conversion: nothing may land
        sensor_sample = 14'sh01f4;
        repeat (50) @(negedge core_clk);
        `CHK("converting", 1'b1, converting)
        alert_mode = 1'b0;
        conv_mode = 2'h2;
        repeat (400) @(negedge core_clk);
        `CHK("converting", 1'b0, converting)
        `CHK("temp_result", 14'sh0000, temp_result)
        step(14'sh0190, 3'h1, 3'h1);
        conv_mode = 2'h1;
        step(14'sh0000, 3'h1, 3'h0);
        repeat (400) @(negedge core_clk);
        `CHK("converting", 1'b0, converting)
        rd();
        complete_run();
    end
endmodule // tb
